// ---- design/asmg_host.v ----
// Host controller for the grouped-select asynchronous SRAM module
// Function
// - Time setup and hold from overlap edges
// - Select or strobe high during address change
// - Address valid before select falls
// - Address timing from last valid line
`include "asmg_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module asmg_host (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // User request port
  input wire REQ,
  input wire REQ_WR,
  input wire [`ASMG_AW-1:0] REQ_ADDR,
  input wire [`ASMG_NG-1:0] REQ_GRP,
  input wire [`ASMG_DW-1:0] REQ_WDATA,
  output reg REQ_BUSY,
  output reg RSP_VALID,
  output reg [`ASMG_DW-1:0] RSP_RDATA,
  // Memory module pins
  output reg [`ASMG_AW-1:0] MEM_ADDR,
  output reg [`ASMG_NG-1:0] MEM_GROUP_SELECT_N,
  output reg MEM_WRITE_N,
  output reg [`ASMG_DW-1:0] MEM_DQ_OUT,
  output reg [`ASMG_DW-1:0] MEM_DQ_OE_N,
  input wire [`ASMG_DW-1:0] MEM_DQ_IN
);
  // One-hot states
  localparam [6:0] ST_IDLE = 7'h01; // Waiting for request
  localparam [6:0] ST_RSET = 7'h02; // Address settles before select
  localparam [6:0] ST_RACC = 7'h04; // Read access window
  localparam [6:0] ST_RHZ = 7'h08; // Wait for device to release bus
  localparam [6:0] ST_WSET = 7'h10; // Strobe low, address and data set
  localparam [6:0] ST_WPUL = 7'h20; // Write overlap pulse
  localparam [6:0] ST_WHLD = 7'h40; // Hold after write ends
  // Counter width covers the longest wait plus synchroniser delay
  localparam CW = 4;
  localparam [CW-1:0] SYNC_LAT = 4'h4;
  // Cycle counts as plain integers, cut to the counter width below
  localparam integer ACC_I = `ASMG_ACC_CYC;
  localparam integer WP_I = `ASMG_WP_CYC;
  localparam integer AS_I = `ASMG_AS_CYC;
  localparam integer DH_I = `ASMG_DH_CYC;
  localparam integer HZ_I = `ASMG_HZ_CYC;
  localparam [CW-1:0] ACC_N = ACC_I[CW-1:0];
  localparam [CW-1:0] WP_N = WP_I[CW-1:0];
  localparam [CW-1:0] AS_N = AS_I[CW-1:0];
  localparam [CW-1:0] DH_N = DH_I[CW-1:0];
  localparam [CW-1:0] HZ_N = HZ_I[CW-1:0];
  reg [6:0] st_ff; // Current state
  reg [6:0] nxt_st; // Next state
  reg [CW-1:0] cnt_ff; // Wait counter
  reg [CW-1:0] nxt_cnt; // Next counter
  reg wr_ff; // Latched direction
  reg [`ASMG_NG-1:0] grp_ff; // Latched active groups, high means used
  reg [`ASMG_DW-1:0] lane_ff; // Latched lanes of the groups
  wire [`ASMG_DW-1:0] dq_sync; // Synchronised read data
  // Expand group mask to data lanes, select n owns bits 4n..4n+3
  function [`ASMG_DW-1:0] grp_lanes;
    input [`ASMG_NG-1:0] g;
    integer k;
    begin
      grp_lanes = {`ASMG_DW{1'b0}};
      for (k = 0; k < `ASMG_DW; k = k + 1)
        grp_lanes[k] = g[k / `ASMG_GW];
    end
  endfunction
  // Read data crosses in from the pins
  asmg_sync #(
    .W(`ASMG_DW)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .din(MEM_DQ_IN),
    .dout(dq_sync)
  );
  // Next-state logic
  always @*
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_IDLE:
      begin
        // Request with no group set is ignored
        if (REQ && (REQ_GRP != 4'h0))
        begin
          nxt_st = REQ_WR ? ST_WSET : ST_RSET;
          nxt_cnt = REQ_WR ? AS_N : 4'h1;
        end
      end
      ST_RSET:
      begin
        nxt_st = ST_RACC;
        nxt_cnt = ACC_N + SYNC_LAT;
      end
      ST_RACC:
      begin
        if (cnt_ff == 4'h1)
        begin
          nxt_st = ST_RHZ;
          nxt_cnt = HZ_N;
        end
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      ST_RHZ:
      begin
        if (cnt_ff == 4'h1)
          nxt_st = ST_IDLE;
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      ST_WSET:
      begin
        if (cnt_ff == 4'h1)
        begin
          nxt_st = ST_WPUL;
          nxt_cnt = WP_N;
        end
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      ST_WPUL:
      begin
        if (cnt_ff == 4'h1)
        begin
          nxt_st = ST_WHLD;
          nxt_cnt = DH_N;
        end
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      ST_WHLD:
      begin
        if (cnt_ff == 4'h1)
          nxt_st = ST_IDLE;
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      default:
      begin
        nxt_st = ST_IDLE;
        nxt_cnt = 4'h0;
      end
    endcase
  end
  // State, latches and pin registers
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      grp_ff <= 4'h0;
      lane_ff <= 16'h0000;
      REQ_BUSY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 16'h0000;
      MEM_ADDR <= 16'h0000;
      MEM_GROUP_SELECT_N <= `ASMG_SEL_IDLE;
      MEM_WRITE_N <= 1'b1;
      MEM_DQ_OUT <= 16'h0000;
      MEM_DQ_OE_N <= 16'hFFFF;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      RSP_VALID <= 1'b0;
      REQ_BUSY <= (nxt_st != ST_IDLE);
      // Capture a request; address changes only with all selects high
      if ((st_ff == ST_IDLE) && (nxt_st != ST_IDLE))
      begin
        wr_ff <= REQ_WR;
        grp_ff <= REQ_GRP;
        lane_ff <= grp_lanes(REQ_GRP);
        MEM_ADDR <= REQ_ADDR;
        MEM_DQ_OUT <= REQ_WDATA;
      end
      // Select pins from next state, per group
      if ((nxt_st == ST_RACC) || (nxt_st == ST_WPUL))
        MEM_GROUP_SELECT_N <= ~((st_ff == ST_IDLE) ? REQ_GRP : grp_ff);
      else
        MEM_GROUP_SELECT_N <= `ASMG_SEL_IDLE;
      // Strobe low through the setup cycle and the write overlap
      MEM_WRITE_N <= ~((nxt_st == ST_WSET) || (nxt_st == ST_WPUL));
      // Host drives lanes while strobe is low and through the hold cycle,
      // when all selects are high, so the device never drives meanwhile
      if ((nxt_st == ST_WSET) || (nxt_st == ST_WPUL) || (nxt_st == ST_WHLD))
        MEM_DQ_OE_N <= ~((st_ff == ST_IDLE) ? grp_lanes(REQ_GRP) : lane_ff);
      else
        MEM_DQ_OE_N <= 16'hFFFF;
      // Sample read data at end of access
      if ((st_ff == ST_RACC) && (cnt_ff == 4'h1) && !wr_ff)
      begin
        RSP_VALID <= 1'b1;
        RSP_RDATA <= dq_sync & lane_ff;
      end
    end
  end
  // Every select fall starts a fresh access; device
  // powers down alone, address is stable for the whole access
endmodule // asmg_host
`default_nettype wire

// ---- design/asmg_defs.vh ----
// Constants for the grouped-select SRAM module host controller
`ifndef ASMG_DEFS_VH
`define ASMG_DEFS_VH
// Clock period in ns (20 MHz)
`define ASMG_CLK_NS 50
// Minimum read access time in ns
`define ASMG_T_ACC_NS 45
// Minimum write pulse (overlap) in ns
`define ASMG_T_WP_NS 40
// Address setup before write in ns
`define ASMG_T_AS_NS 5
// Data hold and address hold after write end in ns
`define ASMG_T_DH_NS 5
// Output turn-off after read in ns
`define ASMG_T_HZ_NS 35
// Cycle counts, least times rounded up, never below one
`define ASMG_CNT(t) ((((t) + `ASMG_CLK_NS - 1) / `ASMG_CLK_NS) < 1 ? 1 : \
  (((t) + `ASMG_CLK_NS - 1) / `ASMG_CLK_NS))
`define ASMG_ACC_CYC `ASMG_CNT(`ASMG_T_ACC_NS)
`define ASMG_WP_CYC `ASMG_CNT(`ASMG_T_WP_NS)
`define ASMG_AS_CYC `ASMG_CNT(`ASMG_T_AS_NS)
`define ASMG_DH_CYC `ASMG_CNT(`ASMG_T_DH_NS)
`define ASMG_HZ_CYC `ASMG_CNT(`ASMG_T_HZ_NS)
// Bus widths and group layout
`define ASMG_AW 16
`define ASMG_DW 16
`define ASMG_NG 4
`define ASMG_GW 4
// Reset values of pins
`define ASMG_SEL_IDLE 4'hF
`endif

// ---- design/asmg_sync.v ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module asmg_sync #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Raw and filtered data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_ff; // First stage, read only by second
  reg [W-1:0] s2_ff; // Second stage
  reg [W-1:0] s3_ff; // Third stage
  integer i;
  // Shift chain; a bit changes when stages two and three agree
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= {W{1'b0}};
      s2_ff <= {W{1'b0}};
      s3_ff <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < W; i = i + 1)
      begin
        // Only accept agreed values
        if (s2_ff[i] == s3_ff[i])
          dout[i] <= s3_ff[i];
      end
    end
  end
endmodule // asmg_sync
`default_nettype wire

// ---- tb/asmg_host_checker.sv ----
// Pin-level assertions for the SRAM host controller
`timescale 1ns/1ns
`default_nettype none
module asmg_host_checker (
  // Clock, reset, user side and group selects
  input wire logic MCLK, RST_N, REQ, REQ_WR, REQ_BUSY, RSP_VALID,
  input wire logic [3:0] REQ_GRP, MEM_GROUP_SELECT_N,
  // Pins and read data
  input wire logic MEM_WRITE_N,
  input wire logic [15:0] RSP_RDATA, MEM_ADDR, MEM_DQ_OE_N
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_read_latency:
    assert property (REQ && !REQ_WR && REQ_GRP != 4'h0 && !REQ_BUSY && !$past(REQ_BUSY)
      |=> !RSP_VALID [*6] ##1 RSP_VALID ##1 !RSP_VALID) else $error("read answer mistimed");
  a_rdata_lanes:
    assert property (RSP_VALID |-> (RSP_RDATA & {{4{$past(MEM_GROUP_SELECT_N[3])}},
      {4{$past(MEM_GROUP_SELECT_N[2])}}, {4{$past(MEM_GROUP_SELECT_N[1])}},
      {4{$past(MEM_GROUP_SELECT_N[0])}}}) == 16'h0000) else $error("idle lane not zero");
  a_read_select:
    assert property (MEM_GROUP_SELECT_N != 4'hF && $past(&MEM_GROUP_SELECT_N) && MEM_WRITE_N
      |-> (MEM_GROUP_SELECT_N != 4'hF && MEM_WRITE_N) [*5] ##1 (&MEM_GROUP_SELECT_N))
      else $error("read select length wrong");
  a_write_overlap:
    assert property ($fell(MEM_WRITE_N) |-> (&MEM_GROUP_SELECT_N) ##1
      MEM_GROUP_SELECT_N != 4'hF ##1 (MEM_WRITE_N && &MEM_GROUP_SELECT_N))
      else $error("write overlap wrong");
  a_strobe_rise:
    assert property ($rose(MEM_WRITE_N) |-> &MEM_GROUP_SELECT_N) else $error("select rose late");
  a_addr_change:
    assert property ($changed(MEM_ADDR) |-> (&MEM_GROUP_SELECT_N || MEM_WRITE_N)
      && (&$past(MEM_GROUP_SELECT_N) || $past(MEM_WRITE_N))) else $error("address moved");
  a_addr_setup:
    assert property (MEM_GROUP_SELECT_N != 4'hF && $past(&MEM_GROUP_SELECT_N)
      |-> $stable(MEM_ADDR)) else $error("address late");
  a_drive_write:
    assert property (MEM_DQ_OE_N != 16'hFFFF |-> !MEM_WRITE_N || (&MEM_GROUP_SELECT_N))
      else $error("drives outside write");
  a_data_hold:
    assert property ($rose(MEM_WRITE_N) |-> MEM_DQ_OE_N != 16'hFFFF ##1 MEM_DQ_OE_N == 16'hFFFF)
      else $error("write data not held");
endmodule // asmg_host_checker
bind asmg_host asmg_host_checker u_chk (.MCLK(MCLK), .RST_N(RST_N), .REQ(REQ),
  .REQ_WR(REQ_WR), .REQ_BUSY(REQ_BUSY), .RSP_VALID(RSP_VALID), .REQ_GRP(REQ_GRP),
  .MEM_GROUP_SELECT_N(MEM_GROUP_SELECT_N), .MEM_WRITE_N(MEM_WRITE_N),
  .RSP_RDATA(RSP_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_DQ_OE_N(MEM_DQ_OE_N));
`default_nettype wire

// ---- tb/asmg_sram_model.sv ----
// Behavioural model of the grouped-select SRAM module
`timescale 1ns/1ns
`default_nettype none
module asmg_sram_model (
  // Host pins
  input wire logic [15:0] addr, hd, hoe_n,
  input wire logic [3:0] sel_n,
  input wire logic we_n,
  // Resolved data wire
  output logic [15:0] dq
);
  logic [15:0] mem [0:65535]; // Word store
  logic [15:0] held = 16'h0000; // Last driven level
  always @*
    for (int i = 0; i < 16; i++)
    begin
      if (!hoe_n[i]) held[i] = hd[i];
      else if (!sel_n[i / 4] && we_n) held[i] = mem[addr][i];
      // Floating lane shows the inverse of its last level
      if (!hoe_n[i] || (!sel_n[i / 4] && we_n)) dq[i] = held[i];
      else dq[i] = ~held[i];
      if (!sel_n[i / 4] && !we_n) mem[addr][i] = dq[i];
    end
endmodule // asmg_sram_model
`default_nettype wire

// ---- tb/test_asmg_host.sv ----
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ns
`default_nettype none
module test_asmg_host;
  logic MCLK = 0, RST_N = 0, REQ = 0, REQ_WR = 0, REQ_BUSY, RSP_VALID, MEM_WRITE_N;
  logic [15:0] REQ_ADDR = 0, REQ_WDATA = 0, RSP_RDATA, MEM_ADDR, MEM_DQ_OUT, MEM_DQ_OE_N;
  logic [15:0] MEM_DQ_IN, rd, m;
  logic [3:0] REQ_GRP = 0, MEM_GROUP_SELECT_N;
  int fails = 0, compares = 0, n;
  asmg_host dut (.MCLK(MCLK), .RST_N(RST_N), .REQ(REQ), .REQ_WR(REQ_WR),
    .REQ_ADDR(REQ_ADDR), .REQ_GRP(REQ_GRP), .REQ_WDATA(REQ_WDATA), .REQ_BUSY(REQ_BUSY),
    .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .MEM_ADDR(MEM_ADDR),
    .MEM_GROUP_SELECT_N(MEM_GROUP_SELECT_N), .MEM_WRITE_N(MEM_WRITE_N),
    .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE_N(MEM_DQ_OE_N), .MEM_DQ_IN(MEM_DQ_IN));
  asmg_sram_model mem (.addr(MEM_ADDR), .hd(MEM_DQ_OUT), .hoe_n(MEM_DQ_OE_N),
    .sel_n(MEM_GROUP_SELECT_N), .we_n(MEM_WRITE_N), .dq(MEM_DQ_IN));
  initial forever #25 MCLK = ~MCLK;
  // Compare one word
  task chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin fails++; $display("CHECK FAILED %0t: %h not %h", $time, got, exp); end
  endtask
  task finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One access; read data lands in rd
  task acc(input logic wr, input logic [15:0] a, input logic [3:0] g, input logic [15:0] d);
    REQ = 1; REQ_WR = wr; REQ_ADDR = a; REQ_GRP = g; REQ_WDATA = d; rd = 'x; n = 0;
    do begin @(posedge MCLK); #1; n++; end while (REQ_BUSY !== 1'b1 && n < 8);
    REQ = 0;
    if (REQ_BUSY !== 1'b1) begin fails++; $display("CHECK FAILED %0t: not taken", $time); finish_test; end
    do begin @(posedge MCLK); #1; n++; if (RSP_VALID === 1'b1) rd = RSP_RDATA; end
    while (REQ_BUSY !== 1'b0 && n < 30);
    if (n >= 30) begin fails++; $display("CHECK FAILED %0t: hang", $time); finish_test; end
    @(posedge MCLK); #1;
  endtask
  task t_reset;
    chk({MEM_GROUP_SELECT_N, 3'h0, MEM_WRITE_N, 7'h0, REQ_BUSY}, 16'hF100);
    chk(MEM_DQ_OE_N, 16'hFFFF);
    $display("reset test done");
  endtask
  task t_word;
    acc(1, 16'hFFFF, 4'hF, 16'hA5C3);
    acc(1, 16'h0000, 4'hF, 16'h5A3C);
    acc(0, 16'hFFFF, 4'hF, 0); chk(rd, 16'hA5C3);
    acc(0, 16'h0000, 4'hF, 0); chk(rd, 16'h5A3C);
    $display("word test done");
  endtask
  task t_groups;
    for (int i = 0; i < 4; i++)
    begin
      m = 16'h000F << (4 * i);
      acc(1, 16'h1234, 4'hF, 16'h0000);
      acc(1, 16'h1234, 4'h1 << i, 16'hFFFF);
      acc(0, 16'h1234, 4'hF, 0); chk(rd, m);
      acc(0, 16'hFFFF, 4'h1 << i, 0); chk(rd, m & 16'hA5C3);
    end
    $display("group test done");
  endtask
  task t_refuse;
    REQ = 1; REQ_WR = 1; REQ_ADDR = 16'hFFFF; REQ_GRP = 4'h0; REQ_WDATA = 16'h0000;
    repeat (4) begin @(posedge MCLK); #1; chk({12'h0, MEM_GROUP_SELECT_N}, 16'h000F); end
    REQ = 0; @(posedge MCLK); #1;
    acc(0, 16'hFFFF, 4'hF, 0); chk(rd, 16'hA5C3);
    $display("refuse test done");
  endtask
  initial begin
    repeat (5) @(posedge MCLK);
    #1 RST_N = 1;
    t_reset; t_word; t_groups; t_refuse;
    finish_test;
  end
endmodule // test_asmg_host
`default_nettype wire
